// [design/sync_serial_defs.vh]
// register offsets, field positions and reset values of the synchronous serial port
`ifndef SYNC_SERIAL_DEFS_VH
`define SYNC_SERIAL_DEFS_VH

`define ADDR_TRANSMIT_CONTROL 8'h00
`define ADDR_RECEIVE_CONTROL 8'h04
`define ADDR_BAUD_CONTROL 8'h08
`define ADDR_BAUD_DIVISOR 8'h0C
`define ADDR_TRANSMIT_HOLDING 8'h10
`define ADDR_RECEIVE_DATA 8'h14
`define ADDR_STATUS 8'h18

`define BIT_CLOCK_SOURCE_MASTER_SELECT 7
`define BIT_SYNC_SELECT 4
`define BIT_SERIAL_PORT_ENABLE 7
`define BIT_SINGLE_RECEIVE_ENABLE 5
`define BIT_CONTINUOUS_RECEIVE_ENABLE 4
`define BIT_CLOCK_POLARITY_SELECT 4

`define BIT_STAT_HOLD_FULL 0
`define BIT_STAT_BUSY 1
`define BIT_STAT_RX_FULL 2
`define BIT_STAT_OVERRUN 3

`define RST_CONTROL 8'h00
`define RST_BAUD_DIVISOR 16'h0003
`define RST_DATA 8'h00

`endif

// [design/sync2.v]
// two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/100ps
module sync2 #(
   parameter W = 1
) (
   input wire clk,
   input wire arst_n,
   input wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end else begin
         meta_ff <= d;
         sync_ff <= meta_ff;
      end
   end

   assign q = sync_ff;
endmodule // sync2

// [design/baud_tick_gen.v]
// half bit period tick generator for the master clock
`timescale 1ns/100ps
module baud_tick_gen #(
   parameter DW = 16
) (
   input wire clk,
   input wire arst_n,
   input wire run,
   input wire [DW-1:0] divisor,
   output wire tick
);
   reg [DW-1:0] count_ff;
   reg [DW-1:0] nxt_count;

   assign tick = run && (count_ff >= divisor);

   always @* begin
      nxt_count = count_ff;
      if (!run || tick) begin
         nxt_count = {DW{1'b0}};
      end else begin
         nxt_count = count_ff + {{(DW-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count_ff <= {DW{1'b0}};
      end else begin
         count_ff <= nxt_count;
      end
   end
endmodule // baud_tick_gen

// [design/sync_serial_master_link.v]
// synchronous half-duplex serial port with apb register access
//
// Function
// (RULE_01) one shared data line plus one clock line
// (RULE_02) half-duplex: never transmit and receive together
// (RULE_03) master makes bit clock from baud divider
// (RULE_04) slave shifts only on received master clock
// (RULE_05) port selectable as master or slave
// (RULE_06) data bits only, no start or stop
// (RULE_07) sync select bit enables synchronous operation
// (RULE_08) clock source bit makes port master
// (RULE_09) both receive enables low means transmit
// (RULE_10) serial port enable bit enables port
// (RULE_11) master drives bit clock on clock pin
// (RULE_12) clock pin driver enabled automatically as master
// (RULE_13) data changes on leading clock edge
// (RULE_14) exactly one clock cycle per data bit
// (RULE_15) polarity set: idle high, change on fall
// (RULE_16) polarity clear: idle low, change on rise
// (RULE_17) master transmit data leaves on data pin
// (RULE_18) software starts transmit by writing holding register
// (RULE_19) new character waits while shift register busy
// (RULE_20) shifting starts right after holding to shift
// (RULE_21) clock idles at selected level between characters
// (RULE_22) bit clock from divider, runs only shifting
`timescale 1ns/100ps
`include "sync_serial_defs.vh"
module sync_serial_master_link #(
   parameter DATA_BITS = 8,
   parameter DIV_W = 16
) (
   input wire CLOCK,
   input wire ARST_N,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [7:0] PADDR,
   input wire [31:0] PWDATA,
   output wire [31:0] PRDATA,
   output wire PREADY,
   output wire PSLVERR,
   input wire TRANSMIT_CLOCK_PIN_I,
   output wire TRANSMIT_CLOCK_PIN_O,
   output wire TRANSMIT_CLOCK_PIN_OE,
   input wire RECEIVE_DATA_PIN_I,
   output wire RECEIVE_DATA_PIN_O,
   output wire RECEIVE_DATA_PIN_OE
);
   ////////////////////////////////////////////////////////////////////////////////
   // address decode
   function is_mapped;
      input [7:0] a;
      begin
         is_mapped = (a == `ADDR_TRANSMIT_CONTROL) || (a == `ADDR_RECEIVE_CONTROL) ||
                     (a == `ADDR_BAUD_CONTROL) || (a == `ADDR_BAUD_DIVISOR) ||
                     (a == `ADDR_TRANSMIT_HOLDING) || (a == `ADDR_RECEIVE_DATA) ||
                     (a == `ADDR_STATUS);
      end
   endfunction

   localparam ST_IDLE = 1'b0;
   localparam ST_SHIFT = 1'b1;
   localparam [3:0] LAST_BIT = DATA_BITS[3:0] - 4'h1;

   reg [7:0] txc_ff;
   reg [7:0] rxc_ff;
   reg [7:0] bdc_ff;
   reg [DIV_W-1:0] div_ff;
   reg [DATA_BITS-1:0] hold_ff;
   reg hold_full_ff;
   reg [DATA_BITS-1:0] shift_ff;
   reg state_ff;
   reg is_rx_ff;
   reg [3:0] bit_cnt_ff;
   reg phase_ff;
   reg ck_ff;
   reg dt_ff;
   reg [DATA_BITS-1:0] rx_data_ff;
   reg rx_full_ff;
   reg ovr_ff;
   reg ck_prev_ff;
   reg [31:0] prdata_ff;
   reg pslverr_ff;

   reg nxt_state;
   reg nxt_is_rx;
   reg [DATA_BITS-1:0] nxt_shift;
   reg [3:0] nxt_bit_cnt;
   reg nxt_phase;
   reg nxt_ck;
   reg nxt_dt;
   reg nxt_hold_full;
   reg [DATA_BITS-1:0] nxt_rx_data;
   reg nxt_rx_full;
   reg nxt_ovr;
   reg nxt_single_receive_enable_clr;
   reg [31:0] nxt_prdata;

   wire [1:0] pin_sync;
   wire ck_in;
   wire dt_in;
   wire tick;
   wire enabled;
   wire master;
   wire rx_mode;
   wire pol;
   wire wr_en;
   wire rd_access;
   wire start;
   wire m_lead;
   wire m_trail;
   wire s_lead;
   wire s_trail;
   wire lead;
   wire trail;
   wire last_bit;

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and divider
   sync2 #(
      .W(2)
   ) u_pin_sync (
      .clk(CLOCK),
      .arst_n(ARST_N),
      .d({TRANSMIT_CLOCK_PIN_I, RECEIVE_DATA_PIN_I}),
      .q(pin_sync)
   );

   assign ck_in = pin_sync[1];
   assign dt_in = pin_sync[0];

   baud_tick_gen #(
      .DW(DIV_W)
   ) u_baud (
      .clk(CLOCK),
      .arst_n(ARST_N),
      .run(master && (state_ff == ST_SHIFT)), // RULE_22
      .divisor(div_ff), // RULE_03
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // mode decode
   assign enabled = rxc_ff[`BIT_SERIAL_PORT_ENABLE] && txc_ff[`BIT_SYNC_SELECT]; // RULE_10
   assign master = txc_ff[`BIT_CLOCK_SOURCE_MASTER_SELECT]; // RULE_08
   assign rx_mode = rxc_ff[`BIT_SINGLE_RECEIVE_ENABLE] ||
                    rxc_ff[`BIT_CONTINUOUS_RECEIVE_ENABLE]; // RULE_09
   assign pol = bdc_ff[`BIT_CLOCK_POLARITY_SELECT];

   assign wr_en = PSEL && PENABLE && PWRITE;
   assign rd_access = PSEL && PENABLE && !PWRITE;

   // RULE_19 RULE_20
   assign start = enabled && (state_ff == ST_IDLE) && (rx_mode || hold_full_ff);

   // RULE_13 RULE_14
   assign m_lead = master && (state_ff == ST_SHIFT) && tick && !phase_ff;
   assign m_trail = master && (state_ff == ST_SHIFT) && tick && phase_ff;
   // RULE_04
   assign s_lead = !master && (state_ff == ST_SHIFT) && (ck_in != ck_prev_ff) && (ck_in != pol);
   assign s_trail = !master && (state_ff == ST_SHIFT) && (ck_in != ck_prev_ff) && (ck_in == pol);
   // RULE_15 RULE_16
   assign lead = m_lead || s_lead;
   assign trail = m_trail || s_trail;
   assign last_bit = trail && (bit_cnt_ff == LAST_BIT); // RULE_14

   ////////////////////////////////////////////////////////////////////////////////
   // shift engine
   always @* begin
      nxt_state = state_ff;
      nxt_is_rx = is_rx_ff;
      nxt_shift = shift_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_phase = phase_ff;
      nxt_ck = ck_ff;
      nxt_dt = dt_ff;
      nxt_hold_full = hold_full_ff;
      nxt_rx_data = rx_data_ff;
      nxt_rx_full = rx_full_ff;
      nxt_ovr = ovr_ff;
      nxt_single_receive_enable_clr = 1'b0;
      if (rd_access && (PADDR == `ADDR_RECEIVE_DATA)) begin
         nxt_rx_full = 1'b0;
         nxt_ovr = 1'b0;
      end
      if (!enabled) begin
         nxt_state = ST_IDLE;
         nxt_bit_cnt = 4'h0;
         nxt_phase = 1'b0;
         nxt_ck = pol;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               nxt_ck = pol; // RULE_21
               nxt_phase = 1'b0;
               nxt_bit_cnt = 4'h0;
               nxt_is_rx = rx_mode; // RULE_02
               if (start) begin
                  nxt_state = ST_SHIFT;
                  if (rx_mode) begin
                     nxt_shift = {DATA_BITS{1'b0}};
                  end else begin
                     nxt_shift = hold_ff; // RULE_20
                     nxt_hold_full = 1'b0;
                  end
               end
            end
            ST_SHIFT: begin
               if (m_lead) begin
                  nxt_ck = ~pol;
                  nxt_phase = 1'b1;
               end
               if (m_trail) begin
                  nxt_ck = pol;
                  nxt_phase = 1'b0;
               end
               if (lead && !is_rx_ff) begin
                  nxt_dt = shift_ff[0]; // RULE_13 RULE_06
                  nxt_shift = {1'b0, shift_ff[DATA_BITS-1:1]};
               end
               if (trail) begin
                  nxt_bit_cnt = bit_cnt_ff + 4'h1;
                  if (is_rx_ff) begin
                     nxt_shift = {dt_in, shift_ff[DATA_BITS-1:1]};
                  end
               end
               if (last_bit) begin
                  nxt_state = ST_IDLE;
                  nxt_bit_cnt = 4'h0;
                  if (is_rx_ff) begin
                     nxt_rx_data = {dt_in, shift_ff[DATA_BITS-1:1]};
                     nxt_rx_full = 1'b1;
                     nxt_single_receive_enable_clr = 1'b1;
                     if (rx_full_ff) begin
                        nxt_ovr = 1'b1;
                     end
                  end
               end
               if (is_rx_ff != rx_mode) begin
                  nxt_state = ST_IDLE; // RULE_02
                  nxt_bit_cnt = 4'h0;
                  nxt_ck = pol; // RULE_21
                  nxt_phase = 1'b0;
               end
            end
            default: begin
               nxt_state = ST_IDLE;
            end
         endcase
      end
      if (wr_en && (PADDR == `ADDR_TRANSMIT_HOLDING)) begin
         nxt_hold_full = 1'b1; // RULE_18
      end
   end

   always @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_ff <= ST_IDLE;
         is_rx_ff <= 1'b0;
         shift_ff <= {DATA_BITS{1'b0}};
         bit_cnt_ff <= 4'h0;
         phase_ff <= 1'b0;
         ck_ff <= 1'b0;
         dt_ff <= 1'b0;
         hold_full_ff <= 1'b0;
         rx_data_ff <= {DATA_BITS{1'b0}};
         rx_full_ff <= 1'b0;
         ovr_ff <= 1'b0;
         ck_prev_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         is_rx_ff <= nxt_is_rx;
         shift_ff <= nxt_shift;
         bit_cnt_ff <= nxt_bit_cnt;
         phase_ff <= nxt_phase;
         ck_ff <= nxt_ck;
         dt_ff <= nxt_dt;
         hold_full_ff <= nxt_hold_full;
         rx_data_ff <= nxt_rx_data;
         rx_full_ff <= nxt_rx_full;
         ovr_ff <= nxt_ovr;
         ck_prev_ff <= ck_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control registers
   always @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         txc_ff <= `RST_CONTROL;
         rxc_ff <= `RST_CONTROL;
         bdc_ff <= `RST_CONTROL;
         div_ff <= `RST_BAUD_DIVISOR;
         hold_ff <= `RST_DATA;
      end else begin
         if (wr_en && (PADDR == `ADDR_TRANSMIT_CONTROL)) begin
            txc_ff <= PWDATA[7:0] & 8'h90; // RULE_05 RULE_07
         end
         if (wr_en && (PADDR == `ADDR_RECEIVE_CONTROL)) begin
            rxc_ff <= PWDATA[7:0] & 8'hB0;
         end else if (nxt_single_receive_enable_clr) begin
            rxc_ff[`BIT_SINGLE_RECEIVE_ENABLE] <= 1'b0;
         end
         if (wr_en && (PADDR == `ADDR_BAUD_CONTROL)) begin
            bdc_ff <= PWDATA[7:0] & 8'h10;
         end
         if (wr_en && (PADDR == `ADDR_BAUD_DIVISOR)) begin
            div_ff <= PWDATA[DIV_W-1:0];
         end
         if (wr_en && (PADDR == `ADDR_TRANSMIT_HOLDING)) begin
            hold_ff <= PWDATA[DATA_BITS-1:0]; // RULE_18
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // apb read path, data taken in setup phase
   always @* begin
      nxt_prdata = 32'h0000_0000;
      case (PADDR)
         `ADDR_TRANSMIT_CONTROL: nxt_prdata[7:0] = txc_ff;
         `ADDR_RECEIVE_CONTROL: nxt_prdata[7:0] = rxc_ff;
         `ADDR_BAUD_CONTROL: nxt_prdata[7:0] = bdc_ff;
         `ADDR_BAUD_DIVISOR: nxt_prdata[DIV_W-1:0] = div_ff;
         `ADDR_TRANSMIT_HOLDING: nxt_prdata[DATA_BITS-1:0] = hold_ff;
         `ADDR_RECEIVE_DATA: nxt_prdata[DATA_BITS-1:0] = rx_data_ff;
         `ADDR_STATUS: begin
            nxt_prdata[`BIT_STAT_HOLD_FULL] = hold_full_ff;
            nxt_prdata[`BIT_STAT_BUSY] = (state_ff == ST_SHIFT);
            nxt_prdata[`BIT_STAT_RX_FULL] = rx_full_ff;
            nxt_prdata[`BIT_STAT_OVERRUN] = ovr_ff;
         end
         default: nxt_prdata = 32'h0000_0000;
      endcase
   end

   always @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         prdata_ff <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else if (PSEL && !PENABLE) begin
         prdata_ff <= nxt_prdata;
         pslverr_ff <= !is_mapped(PADDR);
      end
   end

   assign PRDATA = prdata_ff;
   assign PSLVERR = pslverr_ff && PSEL && PENABLE;
   assign PREADY = 1'b1;

   ////////////////////////////////////////////////////////////////////////////////
   // pin drivers
   assign TRANSMIT_CLOCK_PIN_O = ck_ff; // RULE_11 RULE_21
   assign TRANSMIT_CLOCK_PIN_OE = enabled && master; // RULE_12 RULE_01
   assign RECEIVE_DATA_PIN_O = dt_ff; // RULE_17
   assign RECEIVE_DATA_PIN_OE = enabled && !rx_mode && !is_rx_ff; // RULE_02 RULE_17
endmodule // sync_serial_master_link

// [tb/sync_serial_master_link_sva.sv]
// pin level checker for the synchronous serial port
`timescale 1ns/100ps
`include "sync_serial_defs.vh"
module sync_serial_master_link_sva (
   input wire CLOCK,
   input wire ARST_N,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [7:0] PADDR,
   input wire [31:0] PWDATA,
   input wire [31:0] PRDATA,
   input wire PREADY,
   input wire PSLVERR,
   input wire TRANSMIT_CLOCK_PIN_I,
   input wire TRANSMIT_CLOCK_PIN_O,
   input wire TRANSMIT_CLOCK_PIN_OE,
   input wire RECEIVE_DATA_PIN_I,
   input wire RECEIVE_DATA_PIN_O,
   input wire RECEIVE_DATA_PIN_OE
);
   reg mst_ff, syn_ff, serial_port_enable_ff, rxe_ff, pol_ff, ck_ff;
   reg [2:0] lead_ff;
   reg [4:0] gap_ff;
   wire wr = PSEL && PENABLE && PWRITE && PREADY;
   wire en = syn_ff && serial_port_enable_ff;
   wire edg = TRANSMIT_CLOCK_PIN_OE && (TRANSMIT_CLOCK_PIN_O != ck_ff) && !rxe_ff;
   // shadow of control bits, edge and gap counters
   always @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         {mst_ff, syn_ff, serial_port_enable_ff, rxe_ff, pol_ff, ck_ff} <= 6'h00;
         lead_ff <= 3'h0;
         gap_ff <= 5'h00;
      end else begin
         ck_ff <= TRANSMIT_CLOCK_PIN_O;
         if (wr && PADDR == `ADDR_TRANSMIT_CONTROL) begin
            mst_ff <= PWDATA[`BIT_CLOCK_SOURCE_MASTER_SELECT];
            syn_ff <= PWDATA[`BIT_SYNC_SELECT];
         end
         if (wr && PADDR == `ADDR_RECEIVE_CONTROL) begin
            serial_port_enable_ff <= PWDATA[`BIT_SERIAL_PORT_ENABLE];
            rxe_ff <= PWDATA[5] | PWDATA[4];
         end
         if (wr && PADDR == `ADDR_BAUD_CONTROL)
            pol_ff <= PWDATA[`BIT_CLOCK_POLARITY_SELECT];
         if (TRANSMIT_CLOCK_PIN_O != ck_ff)
            gap_ff <= 5'h00;
         else if (gap_ff != 5'h1F)
            gap_ff <= gap_ff + 5'h01;
         if (edg && TRANSMIT_CLOCK_PIN_O != pol_ff)
            lead_ff <= lead_ff + 3'h1;
      end
   end
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);
   ////////////////////////////////////////////////////////////////////////////////
   // half period of 8 clocks matches the bench divisor of 7
   property p_ck_oe; TRANSMIT_CLOCK_PIN_OE == (en && mst_ff); endproperty
   a_ck_oe: assert property (p_ck_oe) else $error("clock pin enable wrong");
   property p_dt_tx; (en && mst_ff && !rxe_ff) [*3] |-> RECEIVE_DATA_PIN_OE; endproperty
   a_dt_tx: assert property (p_dt_tx) else $error("data pin not driven");
   property p_dt_rx; en && rxe_ff |-> !RECEIVE_DATA_PIN_OE; endproperty
   a_dt_rx: assert property (p_dt_rx) else $error("data driven in rx");
   property p_dis; !en |-> !RECEIVE_DATA_PIN_OE && !TRANSMIT_CLOCK_PIN_OE; endproperty
   a_dis: assert property (p_dis) else $error("pins driven while off");
   property p_lo; edg && TRANSMIT_CLOCK_PIN_O != pol_ff |-> (TRANSMIT_CLOCK_PIN_O != pol_ff) [*8] ##1 TRANSMIT_CLOCK_PIN_O == pol_ff;
   endproperty
   a_lo: assert property (p_lo) else $error("active half wrong");
   property p_hi; edg && TRANSMIT_CLOCK_PIN_O == pol_ff |-> (TRANSMIT_CLOCK_PIN_O == pol_ff) [*8]; endproperty
   a_hi: assert property (p_hi) else $error("idle half short");
   property p_dat;
      RECEIVE_DATA_PIN_OE && $past(RECEIVE_DATA_PIN_OE) && TRANSMIT_CLOCK_PIN_OE && $changed(RECEIVE_DATA_PIN_O)
         |-> TRANSMIT_CLOCK_PIN_O != ck_ff && TRANSMIT_CLOCK_PIN_O != pol_ff;
   endproperty
   a_dat: assert property (p_dat) else $error("data off leading edge");
   property p_bits; gap_ff == 5'h18 |-> lead_ff == 3'h0; endproperty
   a_bits: assert property (p_bits) else $error("clock count wrong");
   c_tx: cover property (edg && TRANSMIT_CLOCK_PIN_O != pol_ff);
   c_err: cover property (PSLVERR);
   c_rx: cover property (en && rxe_ff && TRANSMIT_CLOCK_PIN_O != ck_ff);
endmodule // sync_serial_master_link_sva
bind sync_serial_master_link sync_serial_master_link_sva u_sva (.CLOCK(CLOCK),
   .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .TRANSMIT_CLOCK_PIN_I(TRANSMIT_CLOCK_PIN_I), .TRANSMIT_CLOCK_PIN_O(TRANSMIT_CLOCK_PIN_O), .TRANSMIT_CLOCK_PIN_OE(TRANSMIT_CLOCK_PIN_OE), .RECEIVE_DATA_PIN_I(RECEIVE_DATA_PIN_I),
   .RECEIVE_DATA_PIN_O(RECEIVE_DATA_PIN_O), .RECEIVE_DATA_PIN_OE(RECEIVE_DATA_PIN_OE));

// [tb/sync_slave_model.sv]
// behavioural slave on the synchronous link
`timescale 1ns/100ps
module sync_slave_model (
   input wire clk,
   input wire ck,
   input wire dt,
   input wire pol,
   input wire talk,
   input wire [7:0] tx_byte,
   output reg [7:0] rx_byte,
   output reg [7:0] nbits,
   output reg dout,
   output wire doe
);
   reg ck_ff = 1'b0;
   reg [7:0] sr = 8'h00;
   reg [2:0] idx = 3'h0;
   initial nbits = 8'h00;
   initial rx_byte = 8'h00;
   initial dout = 1'b0;
   assign doe = talk;
   // shifts only on the received clock
   always @(posedge clk) begin
      ck_ff <= ck;
      if (ck != ck_ff && ck == pol) begin
         sr <= {dt, sr[7:1]};
         nbits <= nbits + 8'h01;
         if (nbits[2:0] == 3'h7)
            rx_byte <= {dt, sr[7:1]};
      end
      if (!talk)
         idx <= 3'h0;
      else if (ck != ck_ff && ck != pol) begin
         dout <= tx_byte[idx];
         idx <= idx + 3'h1;
      end
   end
endmodule // sync_slave_model

// [tb/sync_serial_master_link_tb_top.sv]
// self-checking bench for the synchronous serial port
`timescale 1ns/100ps
`include "sync_serial_defs.vh"
module sync_serial_master_link_tb_top;
   reg CLOCK = 1'b0, ARST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   reg [7:0] PADDR = 8'h00;
   reg [31:0] PWDATA = 32'h0000_0000;
   wire [31:0] PRDATA;
   wire PREADY, PSLVERR, ck_o, ck_oe, dt_o, dt_oe, s_do, s_oe;
   wire [7:0] s_rx, s_n;
   reg flip = 1'b0, pol = 1'b0, talk = 1'b0;
   reg [7:0] s_tx = 8'h96, base;
   reg [31:0] q;
   reg e;
   integer bad_count = 0, check_count = 0, i;
   wire ck = ck_oe ? ck_o : pol;
   wire dt = dt_oe ? dt_o : (s_oe ? s_do : flip);
   always #2 CLOCK = ~CLOCK;
   always @(posedge CLOCK) flip <= ~flip;
   sync_serial_master_link dut (.CLOCK(CLOCK), .ARST_N(ARST_N), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .TRANSMIT_CLOCK_PIN_I(ck), .TRANSMIT_CLOCK_PIN_O(ck_o), .TRANSMIT_CLOCK_PIN_OE(ck_oe),
      .RECEIVE_DATA_PIN_I(dt), .RECEIVE_DATA_PIN_O(dt_o), .RECEIVE_DATA_PIN_OE(dt_oe));
   sync_slave_model slv (.clk(CLOCK), .ck(ck), .dt(dt), .pol(pol), .talk(talk),
      .tx_byte(s_tx), .rx_byte(s_rx), .nbits(s_n), .dout(s_do), .doe(s_oe));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input [8*8:1] nm, input [7:0] exp, input [7:0] got);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task apb(input w, input [7:0] a, input [7:0] d);
      begin
         @(posedge CLOCK);
         PSEL <= 1'b1;
         PWRITE <= w;
         PADDR <= a;
         PWDATA <= {24'h00_0000, d};
         @(posedge CLOCK);
         PENABLE <= 1'b1;
         @(posedge CLOCK);
         while (PREADY !== 1'b1) @(posedge CLOCK);
         q = PRDATA;
         e = PSLVERR;
         PSEL <= 1'b0;
         PENABLE <= 1'b0;
         @(posedge CLOCK);
      end
   endtask
   task wait_bits(input [7:0] n);
      for (i = 0; i < 3000 && s_n !== n; i = i + 1) @(posedge CLOCK);
   endtask
   task t_regs;
      begin
         apb(1'b0, `ADDR_BAUD_DIVISOR, 8'h00);
         chk("divisor", 8'h03, q[7:0]);
         apb(1'b0, 8'h1C, 8'h00);
         chk("slverr", 8'h01, {7'h00, e});
         chk("unmapped", 8'h00, q[7:0]);
         chk("ck_oe", 8'h00, {7'h00, ck_oe});
         $display("register test done");
      end
   endtask
   task t_tx;
      begin
         apb(1'b1, `ADDR_BAUD_DIVISOR, 8'h07);
         apb(1'b1, `ADDR_TRANSMIT_CONTROL, 8'h90);
         apb(1'b1, `ADDR_RECEIVE_CONTROL, 8'h80);
         base = s_n;
         chk("ck_oe", 8'h01, {7'h00, ck_oe});
         apb(1'b1, `ADDR_TRANSMIT_HOLDING, 8'h5A);
         apb(1'b1, `ADDR_TRANSMIT_HOLDING, 8'hC3);
         apb(1'b0, `ADDR_STATUS, 8'h00);
         chk("status", 8'h03, q[7:0]);
         wait_bits(base + 8'h08);
         chk("byte0", 8'h5A, s_rx);
         wait_bits(base + 8'h10);
         chk("byte1", 8'hC3, s_rx);
         repeat (40) @(posedge CLOCK);
         chk("nbits", base + 8'h10, s_n);
         chk("ck_idle", 8'h00, {7'h00, ck_o});
         $display("transmit test done");
      end
   endtask
   task t_pol;
      begin
         apb(1'b1, `ADDR_BAUD_CONTROL, 8'h10);
         repeat (4) @(posedge CLOCK);
         pol <= 1'b1;
         chk("ck_idle", 8'h01, {7'h00, ck_o});
         base = s_n;
         apb(1'b1, `ADDR_TRANSMIT_HOLDING, 8'h81);
         wait_bits(base + 8'h08);
         chk("byte2", 8'h81, s_rx);
         $display("polarity test done");
      end
   endtask
   task t_rx;
      begin
         apb(1'b1, `ADDR_RECEIVE_CONTROL, 8'h90);
         talk <= 1'b1;
         chk("dt_oe", 8'h00, {7'h00, dt_oe});
         q = 32'h0000_0000;
         for (i = 0; i < 200 && q[2] !== 1'b1; i = i + 1) apb(1'b0, `ADDR_STATUS, 8'h00);
         apb(1'b0, `ADDR_RECEIVE_DATA, 8'h00);
         chk("rxdata", 8'h96, q[7:0]);
         talk <= 1'b0;
         apb(1'b1, `ADDR_RECEIVE_CONTROL, 8'h80);
         repeat (4) @(posedge CLOCK);
         chk("dt_oe", 8'h01, {7'h00, dt_oe});
         $display("receive test done");
      end
   endtask
   task t_dis;
      begin
         apb(1'b1, `ADDR_TRANSMIT_CONTROL, 8'h10);
         chk("ck_oe", 8'h00, {7'h00, ck_oe});
         apb(1'b1, `ADDR_RECEIVE_CONTROL, 8'h00);
         chk("dt_oe", 8'h00, {7'h00, dt_oe});
         $display("disable test done");
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", check_count, bad_count);
         if (bad_count == 0 && check_count > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   initial begin
      #100000;
      bad_count = bad_count + 1;
      final_report;
   end
   initial begin
      repeat (3) @(posedge CLOCK);
      ARST_N <= 1'b1;
      t_regs;
      t_tx;
      t_pol;
      t_rx;
      t_dis;
      final_report;
   end
endmodule // sync_serial_master_link_tb_top
